// *** src/rfat_bank.sv ***
// Register bank with one field access type per register
`timescale 1ns/1ns
`default_nettype none

// Notes on behaviour
// - Each register has one access type for all its fields.
// - Read-only status returns state; writes are dropped.
// - Readable write-one register: ones set bits, zeros leave them.
// - Flag clear register: ones clear flags, zeros do nothing; reads zero.
// - Unreadable write-one command: ones act, reads give no defined value.
// - Write-only data register accepts writes, reads are undefined.
// - Counter is bus writable and also counted by hardware.
// - Lock register ignores bit set and bit clear accesses.
// - Reading receive data pops it and clears its valid flag.
// - Per-port data-out registers share one layout, one copy each.
// - All registers are 32 bits on a 32-bit bus, except the 16-bit per-port data-out registers.
module rfat_bank
(
	input wire logic CLK_I,
	input wire logic RESETN_I,
	input wire logic SEL_I,
	input wire logic WE_I,
	input wire logic [1:0] OP_I,
	input wire logic [7:0] ADDR_I,
	input wire logic [31:0] WDATA_I,
	input wire logic HW_EVENT_I,
	input wire logic RX_PUSH_I,
	input wire logic [31:0] RX_DATA_I,
	output logic [31:0] RDATA_O,
	output logic ERR_O,
	output logic [31:0] CTRL_O,
	output logic [31:0] ENABLE_O,
	output logic [31:0] CMD_PULSE_O,
	output logic [31:0] WDATA_REG_O,
	output logic [31:0] LOCK_O,
	output logic [63:0] DOUT_O
);

	// -----------------------------------------------------------------
	// Helpers
	// -----------------------------------------------------------------
	// Merge a bus write by operation; shared by every alias-capable reg
	function automatic logic [31:0] merge(input logic [31:0] cur,
		input logic [31:0] wd, input logic [1:0] op);
		logic [31:0] r;
		r = wd;
		if (op == rfat_pkg::OP_SET)
			r = cur | wd;
		else if (op == rfat_pkg::OP_CLR)
			r = cur & ~wd;
		return r;
	endfunction

	// Port window decode, shared by the read and write paths
	function automatic logic is_port(input logic [7:0] a);
		return a >= rfat_pkg::OFS_PORT0 && a < rfat_pkg::OFS_PORT0 +
			rfat_pkg::PORT_STRIDE * 8'(rfat_pkg::NPORT);
	endfunction

	// Port number; low address bits inside a word are ignored
	function automatic logic [1:0] port_idx(input logic [7:0] a);
		return 2'((a - rfat_pkg::OFS_PORT0) / rfat_pkg::PORT_STRIDE);
	endfunction

	// -----------------------------------------------------------------
	// State
	// -----------------------------------------------------------------
	logic [31:0] ctrl_q, ctrl_d, en_q, en_d, if_q, if_d, cmd_q, cmd_d;
	logic [31:0] wreg_q, wreg_d, cnt_q, cnt_d, lock_q, lock_d;
	logic [31:0] rx_q, rx_d, rd_q, rd_d;
	logic rxv_q, rxv_d, err_q, err_d;
	logic [15:0] dout_q [rfat_pkg::NPORT];
	logic [15:0] dout_d [rfat_pkg::NPORT];
	logic wr, rd;

	assign wr = SEL_I & WE_I;
	assign rd = SEL_I & ~WE_I;

	// Next state; each register decodes once with its own type
	always_comb
	begin
		ctrl_d = ctrl_q;
		en_d = en_q;
		if_d = if_q;
		cmd_d = '0; // Command bits are single-cycle pulses
		wreg_d = wreg_q;
		cnt_d = cnt_q + 32'h0000_0001; // Hardware keeps counting
		lock_d = lock_q;
		rx_d = rx_q;
		rxv_d = rxv_q;
		rd_d = rd_q;
		err_d = 1'b0;
		for (int p = 0; p < rfat_pkg::NPORT; p++)
			dout_d[p] = dout_q[p];
		// Read data path, 32-bit words
		if (rd)
		begin
			if (ADDR_I == rfat_pkg::OFS_STATUS)
			begin
				rd_d = rfat_pkg::RST_ZERO;
				rd_d[rfat_pkg::ST_FLAG_BIT] = |if_q;
				rd_d[rfat_pkg::ST_RXV_BIT] = rxv_q;
			end
			else if (ADDR_I == rfat_pkg::OFS_CTRL)
				rd_d = ctrl_q;
			else if (ADDR_I == rfat_pkg::OFS_ENSET)
				rd_d = en_q;
			else if (ADDR_I == rfat_pkg::OFS_IF)
				rd_d = if_q;
			else if (ADDR_I == rfat_pkg::OFS_FLAG_CLEAR)
				rd_d = rfat_pkg::RST_ZERO;
			else if (ADDR_I == rfat_pkg::OFS_CMD)
				rd_d = rfat_pkg::RD_UNDEF;
			else if (ADDR_I == rfat_pkg::OFS_WDATA)
				rd_d = rfat_pkg::RD_UNDEF;
			else if (ADDR_I == rfat_pkg::OFS_CNT)
				rd_d = cnt_q;
			else if (ADDR_I == rfat_pkg::OFS_LOCK)
				rd_d = lock_q;
			else if (ADDR_I == rfat_pkg::OFS_RXDATA)
			begin
				rd_d = rx_q;
				rxv_d = 1'b0; // Read pops the word
			end
			else if (is_port(ADDR_I))
				rd_d = {16'h0, dout_q[port_idx(ADDR_I)]};
			else
			begin
				rd_d = rfat_pkg::ERR_VAL;
				err_d = 1'b1;
			end
		end
		// Write path
		if (wr)
		begin
			if (ADDR_I == rfat_pkg::OFS_STATUS)
				err_d = 1'b0; // Dropped, no state change
			else if (ADDR_I == rfat_pkg::OFS_CTRL)
				ctrl_d = merge(ctrl_q, WDATA_I, OP_I);
			else if (ADDR_I == rfat_pkg::OFS_ENSET)
				en_d = en_q | WDATA_I;
			else if (ADDR_I == rfat_pkg::OFS_FLAG_CLEAR)
				if_d = if_q & ~WDATA_I;
			else if (ADDR_I == rfat_pkg::OFS_CMD)
				cmd_d = WDATA_I;
			else if (ADDR_I == rfat_pkg::OFS_WDATA)
				wreg_d = merge(wreg_q, WDATA_I, OP_I);
			else if (ADDR_I == rfat_pkg::OFS_CNT)
				cnt_d = merge(cnt_q, WDATA_I, OP_I); // Bus wins
			else if (ADDR_I == rfat_pkg::OFS_LOCK)
			begin
				if (OP_I == rfat_pkg::OP_NORMAL)
					lock_d = WDATA_I; // Aliases ignored
			end
			else if (is_port(ADDR_I))
				dout_d[port_idx(ADDR_I)] = 16'(merge({16'h0,
					dout_q[port_idx(ADDR_I)]}, WDATA_I, OP_I));
			else if (ADDR_I != rfat_pkg::OFS_IF && ADDR_I !=
				rfat_pkg::OFS_RXDATA)
				err_d = 1'b1;
		end
		// Hardware sets win over clears in the same cycle
		if (HW_EVENT_I)
			if_d[rfat_pkg::IF_EVENT_BIT] = 1'b1;
		if (RX_PUSH_I)
		begin
			rx_d = RX_DATA_I;
			rxv_d = 1'b1;
			if_d[rfat_pkg::IF_RX_BIT] = 1'b1;
		end
	end

	// Register everything
	always_ff @(posedge CLK_I or negedge RESETN_I)
	begin
		if (!RESETN_I)
		begin
			ctrl_q <= rfat_pkg::RST_CTRL;
			en_q <= rfat_pkg::RST_ZERO;
			if_q <= rfat_pkg::RST_ZERO;
			cmd_q <= rfat_pkg::RST_ZERO;
			wreg_q <= rfat_pkg::RST_ZERO;
			cnt_q <= rfat_pkg::RST_ZERO;
			lock_q <= rfat_pkg::RST_ZERO;
			rx_q <= rfat_pkg::RST_ZERO;
			rd_q <= rfat_pkg::RST_ZERO;
			rxv_q <= 1'b0;
			err_q <= 1'b0;
			for (int p = 0; p < rfat_pkg::NPORT; p++)
				dout_q[p] <= rfat_pkg::RST_DOUT;
		end
		else
		begin
			ctrl_q <= ctrl_d;
			en_q <= en_d;
			if_q <= if_d;
			cmd_q <= cmd_d;
			wreg_q <= wreg_d;
			cnt_q <= cnt_d;
			lock_q <= lock_d;
			rx_q <= rx_d;
			rd_q <= rd_d;
			rxv_q <= rxv_d;
			err_q <= err_d;
			for (int p = 0; p < rfat_pkg::NPORT; p++)
				dout_q[p] <= dout_d[p];
		end
	end

	// -----------------------------------------------------------------
	// Outputs, all from flops
	// -----------------------------------------------------------------
	assign RDATA_O = rd_q;
	assign ERR_O = err_q;
	assign CTRL_O = ctrl_q;
	assign ENABLE_O = en_q;
	assign CMD_PULSE_O = cmd_q;
	assign WDATA_REG_O = wreg_q;
	assign LOCK_O = lock_q;
	assign DOUT_O = {dout_q[3], dout_q[2], dout_q[1], dout_q[0]};

endmodule

`default_nettype wire

// *** src/rfat_pkg.sv ***
// Package for the register bank that demonstrates field access types
package rfat_pkg;
	localparam int DW = 32;
	localparam int AW = 8;
	localparam int NPORT = 4;
	// Operation codes carried on the access type port
	localparam logic [1:0] OP_NORMAL = 2'h0;
	localparam logic [1:0] OP_SET = 2'h1;
	localparam logic [1:0] OP_CLR = 2'h2;
	// Word offsets of the bank
	localparam logic [7:0] OFS_STATUS = 8'h00;
	localparam logic [7:0] OFS_CTRL = 8'h04;
	localparam logic [7:0] OFS_ENSET = 8'h08;
	localparam logic [7:0] OFS_IF = 8'h0C;
	localparam logic [7:0] OFS_FLAG_CLEAR = 8'h10;
	localparam logic [7:0] OFS_CMD = 8'h14;
	localparam logic [7:0] OFS_WDATA = 8'h18;
	localparam logic [7:0] OFS_CNT = 8'h1C;
	localparam logic [7:0] OFS_LOCK = 8'h20;
	localparam logic [7:0] OFS_RXDATA = 8'h24;
	localparam logic [7:0] OFS_PORT0 = 8'h40;
	localparam logic [7:0] PORT_STRIDE = 8'h04;
	// Reset values and fixed read values
	localparam logic [31:0] RST_CTRL = 32'h0000_0000;
	localparam logic [31:0] RST_ZERO = 32'h0000_0000;
	localparam logic [31:0] RD_UNDEF = 32'h0000_0000;
	localparam logic [15:0] RST_DOUT = 16'h0000;
	localparam logic [31:0] ERR_VAL = 32'hDEAD_0BAD;
	// Bit positions in the flag and status words
	localparam int IF_EVENT_BIT = 0;
	localparam int IF_RX_BIT = 1;
	localparam int ST_FLAG_BIT = 0;
	localparam int ST_RXV_BIT = 1;
endpackage

// *** verif/rfat_chk.sv ***
// Checker on the register bank ports
`timescale 1ns/1ns
`default_nettype none
module rfat_chk
(
	input wire logic CLK_I, RESETN_I, SEL_I, WE_I, ERR_O,
	input wire logic [1:0] OP_I,
	input wire logic [7:0] ADDR_I,
	input wire logic [31:0] WDATA_I, RDATA_O, CTRL_O, ENABLE_O,
	input wire logic [31:0] CMD_PULSE_O, LOCK_O
);
	default clocking @(posedge CLK_I); endclocking
	default disable iff (!RESETN_I);
	// Decoded accesses, one per register of interest
	wire logic wr = SEL_I && WE_I;
	wire logic rd = SEL_I && !WE_I;
	wire logic wr_ctl = wr && ADDR_I == 8'h04;
	wire logic wr_enset = wr && ADDR_I == 8'h08 && OP_I == 2'h0;
	wire logic wr_cmd = wr && ADDR_I == 8'h14;
	wire logic wr_lk_alias = wr && ADDR_I == 8'h20 && OP_I != 2'h0;
	wire logic hole = SEL_I && ADDR_I > 8'h24 && ADDR_I < 8'h40;
	AST_RD_CTRL: assert property (rd && ADDR_I == 8'h04 |=>
		RDATA_O == $past(CTRL_O)) else $error("ctrl read");
	AST_ENSET: assert property (wr_enset |=>
		ENABLE_O == ($past(ENABLE_O) | $past(WDATA_I))) else $error("enset");
	AST_FLAG_CLR_RD: assert property (rd && ADDR_I == 8'h10 |=>
		RDATA_O == 32'h0) else $error("flag clear read");
	// Back-to-back command writes are legal, so each pulse is checked alone
	AST_CMD: assert property (wr_cmd |=>
		CMD_PULSE_O == $past(WDATA_I)) else $error("cmd");
	AST_CMD_IDLE: assert property (!wr_cmd |=>
		CMD_PULSE_O == 32'h0) else $error("cmd idle");
	AST_NOALIAS: assert property (wr_lk_alias |=>
		$stable(LOCK_O)) else $error("lock alias");
	AST_SET: assert property (wr_ctl && OP_I == 2'h1 |=>
		CTRL_O == ($past(CTRL_O) | $past(WDATA_I))) else $error("set");
	AST_CLR: assert property (wr_ctl && OP_I == 2'h2 |=>
		CTRL_O == ($past(CTRL_O) & ~$past(WDATA_I))) else $error("clr");
	AST_HOLD: assert property (!wr_ctl |=>
		$stable(CTRL_O)) else $error("ctrl moved");
	// Writes into the hole flag an error but leave the read data alone
	AST_ERR: assert property (hole |=>
		ERR_O && ($past(WE_I) || RDATA_O == 32'hDEAD0BAD))
		else $error("unmapped");
	COV_SET: cover property (wr && OP_I == 2'h1);
	COV_CLR: cover property (wr && OP_I == 2'h2);
	COV_ERR: cover property (ERR_O);
endmodule
`default_nettype wire

// *** verif/rfat_cpu.sv ***
// Processor model issuing one bus access at a time
`timescale 1ns/1ns
`default_nettype none
module rfat_cpu
(
	input wire logic clk_i,
	output logic sel_o = 1'b0, we_o = 1'b0,
	output logic [1:0] op_o = 2'h0,
	output logic [7:0] addr_o = 8'h0,
	output logic [31:0] wdata_o = 32'h0
);
	// Held across the taking edge; idle address and data lines show inverted leftovers
	task acc(input logic w, input logic [1:0] o, input logic [7:0] a,
		input logic [31:0] d);
		@(posedge clk_i);
		#2 {sel_o, we_o, op_o, addr_o, wdata_o} = {1'b1, w, o, a, d};
		@(posedge clk_i);
		#2 {sel_o, addr_o, wdata_o} = {1'b0, ~a, ~d};
	endtask
endmodule
`default_nettype wire

// *** verif/test_register_field_access_types.sv ***
// Self-checking bench for the register bank
`timescale 1ns/1ns
`default_nettype none
module test_register_field_access_types;
	logic clk = 1'b0, rstn = 1'b0, sel, we, ev = 1'b0, push = 1'b0, err;
	logic [1:0] op;
	logic [7:0] addr;
	logic [31:0] wd, rdat, rxd = 32'h0, ctl, en, cmd, wrg, lk, d, em = 0;
	logic [63:0] dout, edo = 64'h0;
	logic [7:0] pa;
	logic [1:0] ro;
	int k;
	int mismatches = 0, n_compared = 0, cyc = 0, seed = 32'h4166;
	always #25 clk = ~clk;
	rfat_cpu cpu(.clk_i(clk), .sel_o(sel), .we_o(we), .op_o(op),
		.addr_o(addr), .wdata_o(wd));
	rfat_bank DUT(.CLK_I(clk), .RESETN_I(rstn), .SEL_I(sel), .WE_I(we),
		.OP_I(op), .ADDR_I(addr), .WDATA_I(wd), .HW_EVENT_I(ev),
		.RX_PUSH_I(push), .RX_DATA_I(rxd), .RDATA_O(rdat), .ERR_O(err),
		.CTRL_O(ctl), .ENABLE_O(en), .CMD_PULSE_O(cmd),
		.WDATA_REG_O(wrg), .LOCK_O(lk), .DOUT_O(dout));
	task chk(input logic [31:0] g, x);
		n_compared++;
		if (g !== x)
		begin
			mismatches++;
			$display("Error %0t got %h exp %h", $time, g, x);
		end
	endtask
	// Expected effect of a write under each alias operation
	function automatic logic [31:0] model(input logic [31:0] c, v,
		input logic [1:0] o);
		if (o == rfat_pkg::OP_SET)
			return c | v;
		if (o == rfat_pkg::OP_CLR)
			return c & ~v;
		return v;
	endfunction
	task final_report;
		if (mismatches == 0 && n_compared > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	task w(input logic [1:0] o, input logic [7:0] a, input logic [31:0] v);
		cpu.acc(1'b1, o, a, v);
	endtask
	task r(input logic [7:0] a, input logic [31:0] x);
		cpu.acc(1'b0, 2'h0, a, 32'h0);
		chk(rdat, x);
	endtask
	// Hang guard well above the expected run
	always @(posedge clk)
	begin
		cyc <= cyc + 1;
		if (cyc == 3000)
		begin
			mismatches++;
			final_report;
		end
	end
	initial
	begin
		repeat (2) @(posedge clk);
		#2 rstn = 1'b1;
		r(8'h04, 32'h0);
		r(8'h30, rfat_pkg::ERR_VAL);
		chk({31'h0, err}, 32'h1);
		w(2'h0, 8'h30, 32'h0);
		chk({31'h0, err}, 32'h1);
		repeat (8)
		begin
			d = $random(seed);
			em = em | d;
			w(2'h0, 8'h04, d);
			r(8'h04, d);
			w(2'h1, 8'h04, ~d);
			chk(ctl, 32'hFFFFFFFF);
			w(2'h2, 8'h04, d);
			chk(ctl, ~d);
			w(2'h0, 8'h08, d);
			chk(en, em);
			w(2'h0, 8'h14, d);
			chk(cmd, d);
			r(8'h14, 32'h0);
			w(2'h0, 8'h18, d);
			chk(wrg, d);
			ro = d[19:18];
			k = int'(d[17:16]);
			w(ro, 8'h18, {d[15:0], d[31:16]});
			chk(wrg, model(d, {d[15:0], d[31:16]}, ro));
			w(2'h0, 8'h20, d);
			w(2'h2, 8'h20, d);
			chk(lk, d);
			w(2'h0, 8'h1C, d);
			r(8'h1C, d + 32'h1);
			w(2'h0, 8'h48, {16'h0, d[15:0]});
			chk({16'h0, dout[47:32]}, {16'h0, d[15:0]});
			edo[47:32] = d[15:0];
			// Random port under a random alias; other ports must keep theirs
			pa = rfat_pkg::OFS_PORT0 + 8'(k) * rfat_pkg::PORT_STRIDE;
			w(ro, pa, {16'h0, d[31:16]});
			edo[16 * k +: 16] = 16'(model({16'h0, edo[16 * k +: 16]},
				{16'h0, d[31:16]}, ro));
			chk(dout[31:0], edo[31:0]);
			chk(dout[63:32], edo[63:32]);
		end
		ev = 1'b1;
		@(posedge clk) #2 ev = 1'b0;
		w(2'h0, 8'h0C, 32'h0);
		w(2'h0, 8'h10, 32'h0);
		r(8'h0C, 32'h1);
		// Flag set and clear land on one edge; the set must win
		fork
			w(2'h0, 8'h10, 32'h1);
			begin
				@(posedge clk) #2 ev = 1'b1;
				@(posedge clk) #2 ev = 1'b0;
			end
		join
		r(8'h0C, 32'h1);
		w(2'h0, 8'h10, 32'h1);
		r(8'h0C, 32'h0);
		rxd = d;
		push = 1'b1;
		@(posedge clk) #2 push = 1'b0;
		r(8'h24, d);
		r(8'h00, 32'h1);
		w(2'h0, 8'h00, 32'h3);
		r(8'h00, 32'h1);
		w(2'h0, 8'h04, 32'h0F0F);
		r(8'h04, 32'h0F0F);
		w(2'h0, 8'h04, (rdat & ~32'hF0) | 32'h50);
		r(8'h04, 32'h0F5F);
		final_report;
	end
endmodule
bind rfat_bank rfat_chk u_chk(.CLK_I(CLK_I), .RESETN_I(RESETN_I),
	.SEL_I(SEL_I), .WE_I(WE_I), .ERR_O(ERR_O), .OP_I(OP_I),
	.ADDR_I(ADDR_I), .WDATA_I(WDATA_I), .RDATA_O(RDATA_O),
	.CTRL_O(CTRL_O), .ENABLE_O(ENABLE_O), .CMD_PULSE_O(CMD_PULSE_O),
	.LOCK_O(LOCK_O));
`default_nettype wire
